// ---- core/clip_dot_params.svh ----
// Purpose: timing counts and operation codes for the clip, compare and dot-product datapath
// Assumes: included by bare name
// Notes: latencies are in processor clock cycles
`ifndef CLIP_DOT_PARAMS_SVH
`define CLIP_DOT_PARAMS_SVH
`define OPC_CLIP_SIGNED 7'd75
`define OPC_CLIP_UNSIGNED 7'd76
`define OPC_EQ_REG 7'd37
`define OPC_EQ_IMM 7'd38
`define OPC_HALFWORD_DOT 7'd94
`define OPC_BYTE_DOT 7'd90
`define LAT_ALU 1
`define LAT_DSPALU 2
`define LAT_DSPMUL 3
`define IMM_WIDTH 7
`define SAT_MAX 32'hFFFFFFFF
`endif

// ---- core/clip_dot_pkg.sv ----
// Purpose: types for the clip, compare and dot-product datapath
// Assumes: nothing
// Notes: operation codes live in clip_dot_params.svh
package clip_dot_pkg;
   typedef logic [31:0] word_t;
   typedef logic [6:0] opcode_t;
   typedef enum logic [1:0] {unit_alu, unit_dspalu, unit_dspmul} unit_e;
endpackage

// ---- core/dot_stage_if.sv ----
// Purpose: carries one issue stage between the top and the product unit
// Assumes: single clock
// Notes: products are returned unreduced so the top owns saturation
`timescale 1ns/10ps
`default_nettype none
interface dot_stage_if;
   logic [31:0] src_one;
   logic [31:0] src_two;
   logic [32:0] halfword_sum;
   logic [17:0] byte_sum;
   modport top (output src_one, output src_two, input halfword_sum, input byte_sum);
   modport unit (input src_one, input src_two, output halfword_sum, output byte_sum);
endinterface
`default_nettype wire

// ---- core/dot_product_unit.sv ----
// Purpose: exact halfword and byte product sums
// Assumes: operands unsigned
// Notes: combinational; the top pipelines the result
`timescale 1ns/10ps
`default_nettype none
module dot_product_unit (
   dot_stage_if.unit st
);
   logic [15:0] byte_prod [4];
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_byte
         assign byte_prod[g] = st.src_one[8*g +: 8] * st.src_two[8*g +: 8];
      end
   endgenerate
   logic [31:0] hi_prod;
   logic [31:0] lo_prod;
   assign hi_prod = st.src_one[31:16] * st.src_two[31:16];
   assign lo_prod = st.src_one[15:0] * st.src_two[15:0];
   // Full-width sums: 33 bits for halfwords, 18 bits never overflow for bytes
   assign st.halfword_sum = {1'b0, hi_prod} + {1'b0, lo_prod};
   assign st.byte_sum = {2'b00, byte_prod[0]} + {2'b00, byte_prod[1]}
      + {2'b00, byte_prod[2]} + {2'b00, byte_prod[3]};
endmodule
`default_nettype wire

// ---- core/clip_dot_datapath.sv ----
// Purpose: guarded execution of clip, equality compare and dot-product operations
// Assumes: issue logic presents one operation per cycle with its opcode and operands
// Notes: results leave on wb_valid after the fixed latency of the operation's unit
// Notes on behaviour
// - Signed clip: min(max(source one,0),source two), two-cycle latency.
// - Unsigned clip: source two if source one larger, else source one; two cycles.
// - Register compare: one if bit-identical, else zero; one-cycle latency.
// - Immediate compare against seven-bit unsigned modifier; one-cycle latency.
// - Halfword dot product: upper and lower unsigned products summed; three cycles.
// - Halfword sum kept exact then saturated to all ones.
// - Byte dot product: four unsigned byte products summed; three cycles.
// - Byte dot product exact, no truncation or saturation.
// - Guard bit zero suppresses the destination write for every operation.
`timescale 1ns/10ps
`default_nettype none
`include "clip_dot_params.svh"
module clip_dot_datapath #(
   parameter int DEST_WIDTH = 7
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Issue
   input wire logic issue_valid,
   input wire logic [6:0] opcode,
   input wire logic [31:0] source_one,
   input wire logic [31:0] source_two,
   input wire logic [`IMM_WIDTH-1:0] modifier,
   input wire logic guard_present,
   input wire logic [31:0] guard_value,
   input wire logic [DEST_WIDTH-1:0] dest_index,
   // Writeback
   output logic wb_valid,
   output logic [DEST_WIDTH-1:0] wb_index,
   output logic [31:0] wb_data,
   // Decode status
   output logic illegal_op
);
   // ==========================================================
   // Decode
   clip_dot_pkg::unit_e unit_sel;
   logic op_known;
   logic guard_true;
   logic write_en;
   logic [1:0] lat;

   always_comb begin
      op_known = 1'b1;
      unit_sel = clip_dot_pkg::unit_alu;
      case (opcode)
         `OPC_EQ_REG: begin
            unit_sel = clip_dot_pkg::unit_alu;
         end
         `OPC_EQ_IMM: begin
            unit_sel = clip_dot_pkg::unit_alu;
         end
         `OPC_CLIP_SIGNED: begin
            unit_sel = clip_dot_pkg::unit_dspalu;
         end
         `OPC_CLIP_UNSIGNED: begin
            unit_sel = clip_dot_pkg::unit_dspalu;
         end
         `OPC_HALFWORD_DOT: begin
            unit_sel = clip_dot_pkg::unit_dspmul;
         end
         `OPC_BYTE_DOT: begin
            unit_sel = clip_dot_pkg::unit_dspmul;
         end
         default: begin
            op_known = 1'b0;
         end
      endcase
   end

   // Latency follows the unit, so a new opcode only needs its unit
   always_comb begin
      case (unit_sel)
         clip_dot_pkg::unit_alu: begin
            lat = 2'(`LAT_ALU);
         end
         clip_dot_pkg::unit_dspalu: begin
            lat = 2'(`LAT_DSPALU);
         end
         clip_dot_pkg::unit_dspmul: begin
            lat = 2'(`LAT_DSPMUL);
         end
         default: begin
            lat = 2'(`LAT_ALU);
         end
      endcase
   end

   // A missing guard reads as true; a present one acts on bit 0 only
   assign guard_true = !guard_present || guard_value[0];
   assign write_en = issue_valid && op_known && guard_true;

   // ==========================================================
   // One- and two-cycle results
   logic [31:0] alu_res;
   logic signed [31:0] s_one;
   logic [31:0] clip_lo;
   logic [31:0] imm_ext;
   logic eq_reg;
   logic eq_imm;

   // Zero-extended, so a source above 127 can never match
   assign imm_ext = {25'h0000000, modifier};
   assign eq_reg = (source_one == source_two);
   assign eq_imm = (source_one == imm_ext);
   assign s_one = source_one;
   // Negative source clamps to zero before the upper bound applies
   assign clip_lo = (s_one < 0) ? 32'h00000000 : source_one;

   always_comb begin
      case (opcode)
         `OPC_EQ_REG: begin
            alu_res = {31'h00000000, eq_reg};
         end
         `OPC_EQ_IMM: begin
            alu_res = {31'h00000000, eq_imm};
         end
         `OPC_CLIP_SIGNED: begin
            // Upper bound stays unsigned even with bit 31 of source two set
            alu_res = (clip_lo > source_two) ? source_two : clip_lo;
         end
         `OPC_CLIP_UNSIGNED: begin
            alu_res = (source_one > source_two) ? source_two : source_one;
         end
         default: begin
            alu_res = 32'h00000000;
         end
      endcase
   end

   // ==========================================================
   // Product unit
   dot_stage_if st ();
   logic hw_over;
   logic [31:0] hw_res;
   logic [31:0] byte_res;
   logic [31:0] dot_res;

   assign st.src_one = source_one;
   assign st.src_two = source_two;

   dot_product_unit u_dot (
      .st(st)
   );

   // Saturate only the final exact sum; a carry out means it passed all ones
   assign hw_over = st.halfword_sum[32];
   assign hw_res = hw_over ? `SAT_MAX : st.halfword_sum[31:0];
   // Eighteen bits always hold four byte products, so no clip is needed
   assign byte_res = {14'h0000, st.byte_sum};

   always_comb begin
      case (opcode)
         `OPC_HALFWORD_DOT: begin
            dot_res = hw_res;
         end
         `OPC_BYTE_DOT: begin
            dot_res = byte_res;
         end
         default: begin
            dot_res = byte_res;
         end
      endcase
   end

   // ==========================================================
   // Latency slots
   // Slot k reaches the writeback register k+1 edges after it is loaded.
   // Ops with different latencies issued back to back could collide;
   // the issue logic schedules writeback ports so that never happens.
   localparam int SLOTS = 3;
   logic [SLOTS-1:0] v_q;
   logic [SLOTS-1:0] v_d;
   logic [31:0] data_q [SLOTS];
   logic [31:0] data_d [SLOTS];
   logic [DEST_WIDTH-1:0] idx_q [SLOTS];
   logic [DEST_WIDTH-1:0] idx_d [SLOTS];
   logic [SLOTS-1:0] load;
   logic [1:0] slot_sel;
   logic [31:0] slot_data;
   logic delayed_wb;

   // Latency two lands in slot 0, latency three in slot 1
   assign delayed_wb = write_en && (lat != 2'(`LAT_ALU));
   assign slot_sel = lat - 2'd2;
   assign slot_data = (unit_sel == clip_dot_pkg::unit_dspmul) ? dot_res : alu_res;

   genvar k;
   generate
      for (k = 0; k < SLOTS; k++) begin : g_slot
         logic shift_v;
         logic [31:0] shift_data;
         logic [DEST_WIDTH-1:0] shift_idx;
         if (k < SLOTS - 1) begin : g_inner
            assign shift_v = v_q[k + 1];
            assign shift_data = data_q[k + 1];
            assign shift_idx = idx_q[k + 1];
         end else begin : g_last
            assign shift_v = 1'b0;
            assign shift_data = 32'h00000000;
            assign shift_idx = '0;
         end
         assign load[k] = delayed_wb && (slot_sel == 2'(k));
         // Reset empties every slot; the data words need no clear
         assign v_d[k] = srst ? 1'b0 : (load[k] || shift_v);
         assign data_d[k] = load[k] ? slot_data : shift_data;
         assign idx_d[k] = load[k] ? dest_index : shift_idx;
      end
   endgenerate

   always_ff @(posedge clk) begin
      v_q <= v_d;
      data_q <= data_d;
      idx_q <= idx_d;
   end

   // ==========================================================
   // Writeback
   logic direct_wb;
   logic wb_valid_d;
   logic [DEST_WIDTH-1:0] wb_index_d;
   logic [31:0] wb_data_d;

   // One-cycle ops bypass the slots and register straight into writeback
   assign direct_wb = write_en && (lat == 2'(`LAT_ALU));

   always_comb begin
      wb_valid_d = v_q[0];
      wb_index_d = idx_q[0];
      wb_data_d = data_q[0];
      if (direct_wb) begin
         wb_valid_d = 1'b1;
         wb_index_d = dest_index;
         wb_data_d = alu_res;
      end
      if (srst) begin
         wb_valid_d = 1'b0;
         wb_index_d = '0;
         wb_data_d = 32'h00000000;
      end
   end

   always_ff @(posedge clk) begin
      wb_valid <= wb_valid_d;
      wb_index <= wb_index_d;
      wb_data <= wb_data_d;
   end

   // ==========================================================
   // Decode status
   logic illegal_d;

   // Unknown opcodes write nothing but are flagged for one cycle
   always_comb begin
      illegal_d = issue_valid && !op_known;
      if (srst) begin
         illegal_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      illegal_op <= illegal_d;
   end
endmodule
`default_nettype wire

// ---- tb/clip_dot_props.sv ----
// Purpose: port checks for the clip, compare and dot datapath
// Assumes: no two writebacks land in one cycle
// Notes: expected results are rebuilt from the operands
`timescale 1ns/10ps
`default_nettype none
module clip_dot_props #(
   parameter int DEST_WIDTH = 7
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Issue
   input wire logic issue_valid,
   input wire logic guard_present,
   input wire logic [6:0] opcode,
   input wire logic [6:0] modifier,
   input wire logic [31:0] source_one,
   input wire logic [31:0] source_two,
   input wire logic [31:0] guard_value,
   input wire logic [DEST_WIDTH-1:0] dest_index,
   // Writeback
   input wire logic wb_valid,
   input wire logic illegal_op,
   input wire logic [DEST_WIDTH-1:0] wb_index,
   input wire logic [31:0] wb_data
);
   // ========
   // Reference
   wire [31:0] a = source_one;
   wire [31:0] b = source_two;
   wire known = opcode inside {7'h25, 7'h26, 7'h4B, 7'h4C, 7'h5A, 7'h5E};
   wire tk = issue_valid && known && (!guard_present || guard_value[0]);
   wire ukn = issue_valid && !known;
   wire [31:0] er = {31'h0, a == b};
   wire [31:0] ei = {31'h0, a == {25'h0, modifier}};
   wire [31:0] uc = a > b ? b : a;
   wire [31:0] sc = a[31] ? 32'h0 : uc;
   // Wide sum so saturation is seen, not wrapped
   wire [32:0] hs = a[31:16] * b[31:16] + a[15:0] * b[15:0];
   wire [31:0] hw = hs[32] ? 32'hFFFFFFFF : hs[31:0];
   wire [31:0] bs = a[31:24] * b[31:24] + a[23:16] * b[23:16] + a[15:8] * b[15:8] + a[7:0] * b[7:0];
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_go(o);
      tk && opcode == o;
   endsequence
   property p_eqr;
      s_go(7'h25) |=> wb_valid && wb_data == $past(er) && wb_index == $past(dest_index);
   endproperty
   property p_eqi;
      s_go(7'h26) |=> wb_valid && wb_data == $past(ei);
   endproperty
   property p_sclip;
      s_go(7'h4B) |-> ##2 wb_valid && wb_data == $past(sc, 2);
   endproperty
   property p_uclip;
      s_go(7'h4C) |-> ##2 wb_valid && wb_data == $past(uc, 2);
   endproperty
   property p_hdot;
      s_go(7'h5E) |-> ##3 wb_valid && wb_data == $past(hw, 3);
   endproperty
   property p_bdot;
      s_go(7'h5A) |-> ##3 wb_valid && wb_data == $past(bs, 3);
   endproperty
   property p_spur;
      wb_valid |-> $past(tk) || $past(tk, 2) || $past(tk, 3);
   endproperty
   property p_ill;
      ukn |=> illegal_op;
   endproperty
   a_eqr: assert property (p_eqr) else $error("reg compare wrong");
   a_eqi: assert property (p_eqi) else $error("imm compare wrong");
   a_sclip: assert property (p_sclip) else $error("signed clip wrong");
   a_uclip: assert property (p_uclip) else $error("unsigned clip wrong");
   a_hdot: assert property (p_hdot) else $error("halfword sum wrong");
   a_bdot: assert property (p_bdot) else $error("byte sum wrong");
   a_spur: assert property (p_spur) else $error("write without issue");
   a_ill: assert property (p_ill) else $error("unknown opcode not flagged");
endmodule
`default_nettype wire

// ---- tb/issue_model.sv ----
// Purpose: stands in for the issue logic and register file
// Assumes: bench calls its tasks in order
// Notes: idle cycles flip operands so stale values cannot pass
`timescale 1ns/10ps
`default_nettype none
module issue_model (
   // Clock
   input wire logic clk,
   // Issue
   output logic issue_valid,
   output logic guard_present,
   output logic [6:0] opcode,
   output logic [6:0] modifier,
   output logic [6:0] dest_index,
   output logic [31:0] source_one,
   output logic [31:0] source_two,
   output logic [31:0] guard_value
);
   // ========
   // Drive
   initial {issue_valid, guard_present, opcode, modifier, dest_index, source_one} = '0;
   initial {source_two, guard_value} = '0;
   task automatic put(input logic [6:0] o, m, input logic [31:0] a, b, input logic g,
      input logic [31:0] w);
      @(posedge clk);
      issue_valid <= 1'b1;
      {opcode, modifier, source_one, source_two, guard_present, guard_value} <= {o, m, a, b, g, w};
      dest_index <= dest_index + 7'h01;
   endtask
   task automatic idle();
      @(posedge clk);
      issue_valid <= 1'b0;
      source_one <= ~source_one;
      source_two <= ~source_two;
   endtask
endmodule
`default_nettype wire

// ---- tb/clip_dot_bench.sv ----
// Purpose: self-checking bench for the clip, compare and dot datapath
// Assumes: DEST_WIDTH left at its default
// Notes: row table first, then guard, opcode and back-to-back cases
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
   $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module unsigned_clip_compare_dot_product_ops_bench;
   logic clk, srst, issue_valid, guard_present, wb_valid, illegal_op;
   logic [6:0] opcode, modifier, dest_index, wb_index;
   logic [31:0] source_one, source_two, guard_value, wb_data;
   int failures = 0, total_checks = 0, n;
   // Row: opcode, modifier, source one, source two, result
   logic [109:0] rows [16] = '{
      {7'h4B, 7'h0, 32'h80, 32'h7F, 32'h7F}, {7'h4B, 7'h0, 32'h12345678, 32'hABC, 32'hABC},
      {7'h4B, 7'h0, 32'h80000000, 32'h3FFFFF, 32'h0}, {7'h4C, 7'h0, 32'h80, 32'h7F, 32'h7F},
      {7'h4C, 7'h0, 32'h80000000, 32'h3FFFFF, 32'h3FFFFF}, {7'h25, 7'h0, 32'h3, 32'h4, 32'h0},
      {7'h25, 7'h0, 32'h80000000, 32'h80000000, 32'h1}, {7'h26, 7'h3, 32'h3, 32'h0, 32'h1},
      {7'h26, 7'h4, 32'h3, 32'h0, 32'h0}, {7'h26, 7'h7F, 32'h7F, 32'h0, 32'h1},
      {7'h5E, 7'h0, 32'h20003, 32'h10002, 32'h8}, {7'h5E, 7'h0, 32'h20003, 32'h648000, 32'h180C8},
      {7'h5E, 7'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF},
      {7'h5A, 7'h0, 32'hAFB14F6, 32'hA0A1414, 32'h1EFA},
      {7'h5A, 7'h0, 32'h80808080, 32'hFFFFFFFF, 32'h1FE00},
      {7'h5A, 7'h0, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h3F804}};
   clip_dot_datapath DUT (.clk, .srst, .issue_valid, .opcode, .source_one, .source_two,
      .modifier, .guard_present, .guard_value, .dest_index, .wb_valid, .wb_index,
      .wb_data, .illegal_op);
   issue_model P (.clk, .issue_valid, .guard_present, .opcode, .modifier, .dest_index,
      .source_one, .source_two, .guard_value);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Latency 6 means no write expected; 0 means take it from the opcode
   task automatic run(input logic [109:0] r, input logic g, input logic [31:0] w, input int l);
      if (l == 0) l = r[109:103] < 7'h40 ? 1 : r[109:103] < 7'h50 ? 2 : 3;
      P.put(r[109:103], r[102:96], r[95:64], r[63:32], g, w);
      for (n = 1; n < 6; n++) begin
         P.idle();
         #1;
         if (wb_valid === 1'b1) break;
      end
      `CHK({n[3:0], n < 6 ? wb_data : 32'h0}, {l[3:0], r[31:0]})
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      srst = 1'b1;
      repeat (8) @(posedge clk);
      `CHK({wb_valid, illegal_op}, 2'b00)
      srst <= 1'b0;
      foreach (rows[i]) run(rows[i], 1'b0, 32'h0, 0);
      $display("table rows done");
      run({7'h5E, 7'h0, 32'h80000064, 32'h648000, 32'h0}, 1'b1, 32'h0, 6);
      run({7'h5E, 7'h0, 32'h80000064, 32'h648000, 32'h640000}, 1'b1, 32'h1, 3);
      run({7'h5A, 7'h0, 32'hAFB14F6, 32'hA0A1414, 32'h0}, 1'b1, 32'hFFFFFFFE, 6);
      run({7'h7F, 7'h0, 32'h1, 32'h1, 32'h0}, 1'b0, 32'h0, 6);
      $display("guard and opcode cases done");
      P.put(7'h7F, 7'h0, 32'h1, 32'h1, 1'b0, 32'h0);
      P.idle();
      #1;
      `CHK({wb_valid, illegal_op}, 2'b01)
      P.put(7'h25, 7'h0, 32'h5, 32'h5, 1'b0, 32'h0);
      P.put(7'h4C, 7'h0, 32'h9, 32'h4, 1'b0, 32'h0);
      #1;
      `CHK({wb_valid, wb_data, wb_index}, {1'b1, 32'h1, P.dest_index - 7'h01})
      P.put(7'h5A, 7'h0, 32'h01010101, 32'h02020202, 1'b0, 32'h0);
      P.idle();
      #1;
      `CHK({wb_valid, wb_data, wb_index}, {1'b1, 32'h4, P.dest_index - 7'h01})
      repeat (2) P.idle();
      #1;
      `CHK({wb_valid, wb_data, wb_index}, {1'b1, 32'h8, P.dest_index})
      repeat (2) P.idle();
      $display("back to back done");
      P.put(7'h5A, 7'h0, 32'h01010101, 32'h02020202, 1'b0, 32'h0);
      P.idle();
      srst <= 1'b1;
      P.idle();
      srst <= 1'b0;
      for (n = 0; n < 4; n++) begin
         P.idle();
         #1;
         `CHK({wb_valid, illegal_op}, 2'b00)
      end
      $display("mid-run reset done");
      print_verdict();
   end
endmodule
bind clip_dot_datapath clip_dot_props #(.DEST_WIDTH(DEST_WIDTH)) chk (.clk, .srst,
   .issue_valid, .guard_present, .opcode, .modifier, .source_one, .source_two,
   .guard_value, .dest_index, .wb_valid, .illegal_op, .wb_index, .wb_data);
`default_nettype wire
